// >>> include/spi_pkg.sv
// Package: offsets, fields, resets and request types for the port identity/command block
package spi_pkg;
   localparam logic [11:0] SPI_OFF_IDENT = 12'h000;
   localparam logic [11:0] SPI_OFF_CMD = 12'h004;
   localparam int SPI_MAKER_LSB = 0;
   localparam int SPI_PART_LSB = 16;
   localparam int SPI_CMD_IO_EN = 0;
   localparam int SPI_CMD_MEM_EN = 1;
   localparam int SPI_CMD_MASTER_EN = 2;
   localparam int SPI_CMD_PARITY_RESP = 6;
   localparam int SPI_CMD_SYS_ERR_EN = 8;
   localparam int SPI_CMD_INTX_DIS = 10;
   // Writable command bits; all others read zero
   localparam logic [15:0] SPI_CMD_WR_MASK = 16'h0547;
   localparam logic [15:0] SPI_CMD_RESET = 16'h0000;
   // Arbitrary neutral identifier defaults
   localparam logic [15:0] SPI_MAKER_RESET = 16'hA5A5;
   localparam logic [15:0] SPI_PART_RESET = 16'h5A5A;
   typedef enum logic [1:0] {
      SPI_REQ_MEM = 2'h0,
      SPI_REQ_IO = 2'h1,
      SPI_REQ_OTHER = 2'h2
   } spi_req_type;
endpackage

// >>> include/spi_ident_if.sv
// Interface: identifier override path between top and identifier store
`timescale 1ns/1ps
`default_nettype none
interface spi_ident_if;
   logic load;
   logic [15:0] load_maker;
   logic [15:0] load_part;
   logic [15:0] maker;
   logic [15:0] part;
   modport store (input load, input load_maker, input load_part, output maker, output part);
   modport user (output load, output load_maker, output load_part, input maker, input part);
endinterface
`default_nettype wire

// >>> rtl/spi_ident_store.sv
// Identifier store: reset defaults, replaceable only by sideband load
`timescale 1ns/1ps
`default_nettype none
module spi_ident_store
   import spi_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   spi_ident_if.store idp
);
   // ==========================================
   // Identifier registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         idp.maker <= SPI_MAKER_RESET; // RL1
         idp.part <= SPI_PART_RESET; // RL2
      end else if (clk_en && idp.load) begin
         idp.maker <= idp.load_maker; // RL3
         idp.part <= idp.load_part; // RL3
      end
   end

   // ==========================================
   // Checks
   property p_maker_load;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && idp.load |=> idp.maker == $past(idp.load_maker);
   endproperty
   a_maker_load: assert property (p_maker_load) else $error("maker load lost"); // RL3
   property p_part_load;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && idp.load |=> idp.part == $past(idp.load_part);
   endproperty
   a_part_load: assert property (p_part_load) else $error("part load lost"); // RL3
   property p_maker_hold;
      @(posedge mclk) disable iff (!rst_b)
      !(clk_en && idp.load) |=> $stable(idp.maker);
   endproperty
   a_maker_hold: assert property (p_maker_hold) else $error("maker changed without load"); // RL1
   property p_part_hold;
      @(posedge mclk) disable iff (!rst_b)
      !(clk_en && idp.load) |=> $stable(idp.part);
   endproperty
   a_part_hold: assert property (p_part_hold) else $error("part changed without load"); // RL2
endmodule
`default_nettype wire

// >>> rtl/spi_port_regs.sv
// Port identity and command registers with request gating
//
// Functional notes
// RL1: Maker identifier read-only at 00h bits 15:0
// RL2: Part identifier read-only at 00h bits 31:16
// RL3: Identifiers replaceable by sideband or EEPROM load
// RL4: Bit 0 gates primary I/O response
// RL5: Bit 1 gates primary memory response
// RL6: Bit 2 clear blocks upstream, flags UR
// RL7: Non-posted UR request gets UR completion
// RL8: Bit 2 set forwards upstream memory/I/O
// RL9: Legacy command bits read as zero
// RL10: Bit 6 enables parity-error handling
// RL11: Bit 8 gates fatal/non-fatal error reporting
// RL12: Bit 10 suppresses own INTx generation
// RL13: INTx forwarding unaffected by bit 10
// RL14: Command bits reset to zero
// RL15: Bits 15:11 reserved, writes ignored
// RL16: Config writes to 00h ignored; reads current
`timescale 1ns/1ps
`default_nettype none
module spi_port_regs
   import spi_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Configuration access from root complex, same clock
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic [3:0] cfg_be,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   // Sideband identifier load (SMBus or EEPROM loader)
   input wire logic id_load,
   input wire logic [15:0] id_load_maker,
   input wire logic [15:0] id_load_part,
   // Primary-side request
   input wire logic pri_req,
   input wire spi_req_type pri_type,
   output logic pri_accept,
   // Downstream request heading upstream
   input wire logic dn_req,
   input wire spi_req_type dn_type,
   input wire logic dn_nonposted,
   output logic up_fwd,
   output logic dn_ur,
   output logic dn_ur_cpl,
   // Error and interrupt events
   input wire logic parity_err,
   input wire logic fatal_err,
   input wire logic nonfatal_err,
   input wire logic own_intx,
   input wire logic fwd_intx,
   output logic parity_act,
   output logic err_fatal_msg,
   output logic err_nonfatal_msg,
   output logic intx_msg,
   output logic intx_fwd_msg
);
   logic [15:0] cmd;
   logic [15:0] next_cmd;
   logic is_mem_io;
   spi_ident_if idb();

   // ==========================================
   // Identifier store
   assign idb.load = id_load;
   assign idb.load_maker = id_load_maker;
   assign idb.load_part = id_load_part;

   spi_ident_store u_ident (
      .mclk(mclk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .idp(idb.store)
   );

   // ==========================================
   // Command register
   always_comb begin
      next_cmd = cmd;
      if (cfg_wr && cfg_addr == SPI_OFF_CMD) begin
         // Only writable bits change; legacy and reserved stay zero
         if (cfg_be[0]) begin
            next_cmd[7:0] = cfg_wdata[7:0] & SPI_CMD_WR_MASK[7:0]; // RL9
         end
         if (cfg_be[1]) begin
            next_cmd[15:8] = cfg_wdata[15:8] & SPI_CMD_WR_MASK[15:8]; // RL15
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cmd <= SPI_CMD_RESET; // RL14
      end else if (clk_en) begin
         cmd <= next_cmd;
      end
   end

   // ==========================================
   // Read path
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
      end else if (clk_en) begin
         cfg_rvalid <= cfg_rd;
         if (cfg_rd) begin
            if (cfg_addr == SPI_OFF_IDENT) begin
               cfg_rdata <= {idb.part, idb.maker}; // RL16
            end else if (cfg_addr == SPI_OFF_CMD) begin
               // Status half lies outside this block, reads zero
               cfg_rdata <= {16'h0000, cmd};
            end else begin
               cfg_rdata <= 32'h0000_0000;
            end
         end
      end
   end

   // ==========================================
   // Request gating
   assign is_mem_io = (dn_type == SPI_REQ_MEM) || (dn_type == SPI_REQ_IO);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pri_accept <= 1'b0;
         up_fwd <= 1'b0;
         dn_ur <= 1'b0;
         dn_ur_cpl <= 1'b0;
      end else if (clk_en) begin
         pri_accept <= pri_req &&
            ((pri_type == SPI_REQ_IO && cmd[SPI_CMD_IO_EN]) || // RL4
             (pri_type == SPI_REQ_MEM && cmd[SPI_CMD_MEM_EN])); // RL5
         up_fwd <= dn_req && is_mem_io && cmd[SPI_CMD_MASTER_EN]; // RL8
         dn_ur <= dn_req && is_mem_io && !cmd[SPI_CMD_MASTER_EN]; // RL6
         dn_ur_cpl <= dn_req && is_mem_io && dn_nonposted && !cmd[SPI_CMD_MASTER_EN]; // RL7
      end
   end

   // ==========================================
   // Error and interrupt gating
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         parity_act <= 1'b0;
         err_fatal_msg <= 1'b0;
         err_nonfatal_msg <= 1'b0;
         intx_msg <= 1'b0;
         intx_fwd_msg <= 1'b0;
      end else if (clk_en) begin
         parity_act <= parity_err && cmd[SPI_CMD_PARITY_RESP]; // RL10
         err_fatal_msg <= fatal_err && cmd[SPI_CMD_SYS_ERR_EN]; // RL11
         err_nonfatal_msg <= nonfatal_err && cmd[SPI_CMD_SYS_ERR_EN]; // RL11
         intx_msg <= own_intx && !cmd[SPI_CMD_INTX_DIS]; // RL12
         // Forwarded INTx ignores the disable bit
         intx_fwd_msg <= fwd_intx; // RL13
      end
   end

   // ==========================================
   // Checks
   property p_ident_ro;
      @(posedge mclk) disable iff (!rst_b)
      !(clk_en && id_load) |=> $stable({idb.part, idb.maker});
   endproperty
   a_ident_ro: assert property (p_ident_ro) else $error("identifier changed"); // RL16
   property p_ident_rd;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && cfg_rd && cfg_addr == SPI_OFF_IDENT
         |=> cfg_rdata == {$past(idb.part), $past(idb.maker)};
   endproperty
   a_ident_rd: assert property (p_ident_rd) else $error("identifier read wrong"); // RL16
   property p_rd_valid;
      @(posedge mclk) disable iff (!rst_b)
      clk_en |=> cfg_rvalid == $past(cfg_rd);
   endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read valid mistimed"); // RL16

   property p_legacy_zero;
      @(posedge mclk) disable iff (!rst_b)
      cmd[15:11] == 5'h00 && cmd[9] == 1'b0 && cmd[7] == 1'b0 && cmd[5:3] == 3'h0;
   endproperty
   a_legacy_zero: assert property (p_legacy_zero) else $error("legacy command bit set"); // RL9
   property p_cmd_rd;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && cfg_rd && cfg_addr == SPI_OFF_CMD |=> cfg_rdata == {16'h0000, $past(cmd)};
   endproperty
   a_cmd_rd: assert property (p_cmd_rd) else $error("command read wrong"); // RL9
   property p_cmd_mask;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && cfg_wr && cfg_addr == SPI_OFF_CMD && cfg_be[1:0] == 2'h3
         |=> cmd == ($past(cfg_wdata[15:0]) & SPI_CMD_WR_MASK);
   endproperty
   a_cmd_mask: assert property (p_cmd_mask) else $error("command write not masked"); // RL15
   property p_cmd_hold;
      @(posedge mclk) disable iff (!rst_b)
      !(clk_en && cfg_wr && cfg_addr == SPI_OFF_CMD) |=> $stable(cmd);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without write"); // RL15

   property p_io_gate;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && pri_req && pri_type == SPI_REQ_IO
         |=> pri_accept == $past(cmd[SPI_CMD_IO_EN]);
   endproperty
   a_io_gate: assert property (p_io_gate) else $error("I/O response not per enable"); // RL4
   property p_mem_gate;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && pri_req && pri_type == SPI_REQ_MEM
         |=> pri_accept == $past(cmd[SPI_CMD_MEM_EN]);
   endproperty
   a_mem_gate: assert property (p_mem_gate) else $error("memory response not per enable"); // RL5
   property p_ur;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && dn_req && is_mem_io && !cmd[SPI_CMD_MASTER_EN] |=> dn_ur && !up_fwd;
   endproperty
   a_ur: assert property (p_ur) else $error("mastering off but no UR"); // RL6
   property p_ur_cpl;
      @(posedge mclk) disable iff (!rst_b)
      dn_ur_cpl |-> dn_ur;
   endproperty
   a_ur_cpl: assert property (p_ur_cpl) else $error("UR completion without UR"); // RL7
   property p_ur_cpl_send;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && dn_req && is_mem_io && dn_nonposted && !cmd[SPI_CMD_MASTER_EN]
         |=> dn_ur_cpl;
   endproperty
   a_ur_cpl_send: assert property (p_ur_cpl_send) else $error("UR completion missing"); // RL7
   property p_fwd;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && dn_req && is_mem_io && cmd[SPI_CMD_MASTER_EN] |=> up_fwd && !dn_ur;
   endproperty
   a_fwd: assert property (p_fwd) else $error("mastering on but not forwarded"); // RL8

   property p_serr;
      @(posedge mclk) disable iff (!rst_b)
      (err_fatal_msg || err_nonfatal_msg) |-> $past(cmd[SPI_CMD_SYS_ERR_EN]);
   endproperty
   a_serr: assert property (p_serr) else $error("error message while reporting off"); // RL11
   property p_serr_on;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && cmd[SPI_CMD_SYS_ERR_EN]
         |=> err_fatal_msg == $past(fatal_err) && err_nonfatal_msg == $past(nonfatal_err);
   endproperty
   a_serr_on: assert property (p_serr_on) else $error("error message dropped"); // RL11
   property p_intx;
      @(posedge mclk) disable iff (!rst_b)
      intx_msg |-> !$past(cmd[SPI_CMD_INTX_DIS]);
   endproperty
   a_intx: assert property (p_intx) else $error("INTx while disabled"); // RL12
   property p_intx_on;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && own_intx && !cmd[SPI_CMD_INTX_DIS] |=> intx_msg;
   endproperty
   a_intx_on: assert property (p_intx_on) else $error("own INTx dropped"); // RL12
   property p_fwd_intx;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && fwd_intx |=> intx_fwd_msg;
   endproperty
   a_fwd_intx: assert property (p_fwd_intx) else $error("forwarded INTx dropped"); // RL13
   property p_fwd_intx_only;
      @(posedge mclk) disable iff (!rst_b)
      intx_fwd_msg |-> $past(fwd_intx);
   endproperty
   a_fwd_intx_only: assert property (p_fwd_intx_only) else $error("spurious forwarded INTx"); // RL13
   property p_parity;
      @(posedge mclk) disable iff (!rst_b)
      parity_act |-> $past(cmd[SPI_CMD_PARITY_RESP]);
   endproperty
   a_parity: assert property (p_parity) else $error("parity act while off"); // RL10
   property p_parity_on;
      @(posedge mclk) disable iff (!rst_b)
      clk_en && parity_err && cmd[SPI_CMD_PARITY_RESP] |=> parity_act;
   endproperty
   a_parity_on: assert property (p_parity_on) else $error("parity action dropped"); // RL10
endmodule
`default_nettype wire

// >>> dv/spi_rc_model.sv
// Root complex stand-in issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module spi_rc_model (
   input wire logic mclk,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [11:0] cfg_addr,
   output logic [31:0] cfg_wdata,
   output logic [3:0] cfg_be,
   input wire logic [31:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 12'h000;
      cfg_wdata = 32'h0;
      cfg_be = 4'h0;
   end
   // Released address and data lines show the inverse so stale values never look valid
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge mclk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_be <= be;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output bit ok);
      int n;
      @(posedge mclk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge mclk);
      cfg_rd <= 1'b0;
      cfg_addr <= ~a;
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge mclk);
         ok = (cfg_rvalid === 1'b1);
      end
      d = cfg_rdata;
   endtask
endmodule
`default_nettype wire

// >>> dv/switch_port_ident_command_regs_tb_top.sv
// Testbench: register model and gating model compared with the port block
`timescale 1ns/1ps
`default_nettype none
module switch_port_ident_command_regs_tb_top
   import spi_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic cfg_wr, cfg_rd, cfg_rvalid, id_load = 1'b0;
   logic [11:0] cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, r, rd_v;
   logic [3:0] cfg_be;
   logic [15:0] id_load_maker = 16'h0, id_load_part = 16'h0, cmd = 16'h0, m;
   logic [15:0] maker = SPI_MAKER_RESET, part = SPI_PART_RESET;
   logic pri_req = 1'b0, dn_req = 1'b0, dn_nonposted = 1'b0, parity_err = 1'b0;
   logic fatal_err = 1'b0, nonfatal_err = 1'b0, own_intx = 1'b0, fwd_intx = 1'b0;
   spi_req_type pri_type = SPI_REQ_MEM, dn_type = SPI_REQ_MEM;
   logic pri_accept, up_fwd, dn_ur, dn_ur_cpl, parity_act, err_fatal_msg;
   logic err_nonfatal_msg, intx_msg, intx_fwd_msg;
   logic [31:0] seed = 32'h0000_1186;
   int err_total = 0, check_count = 0, i;
   always #50 mclk = ~mclk;
   spi_rc_model u_rc (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
   spi_port_regs dut (.mclk(mclk), .rst_b(rst_b), .clk_en(1'b1), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .id_load(id_load),
      .id_load_maker(id_load_maker), .id_load_part(id_load_part), .pri_req(pri_req),
      .pri_type(pri_type), .pri_accept(pri_accept), .dn_req(dn_req), .dn_type(dn_type),
      .dn_nonposted(dn_nonposted), .up_fwd(up_fwd), .dn_ur(dn_ur), .dn_ur_cpl(dn_ur_cpl),
      .parity_err(parity_err), .fatal_err(fatal_err), .nonfatal_err(nonfatal_err),
      .own_intx(own_intx), .fwd_intx(fwd_intx), .parity_act(parity_act),
      .err_fatal_msg(err_fatal_msg), .err_nonfatal_msg(err_nonfatal_msg),
      .intx_msg(intx_msg), .intx_fwd_msg(intx_fwd_msg));
   // ==========================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      bit ok;
      u_rc.rd(a, rd_v, ok);
      if (!ok) begin
         err_total++;
         $display("BAD t=%0t read never answered", $time);
         give_verdict();
      end else begin
         check(rd_v, exp);
      end
   endtask
   // One cycle of latency: each check sees the inputs of the previous cycle
   task automatic events(input int cycles);
      logic [8:0] exp, nxt;
      logic [1:0] pt, dt;
      logic mio;
      int k;
      exp = 9'h0;
      for (k = 0; k <= cycles; k++) begin
         @(posedge mclk);
         r = (k == cycles) ? 32'h0 : rnd();
         pt = r[2:1] % 2'h3;
         dt = r[5:4] % 2'h3;
         mio = r[3] && dt != 2'h2;
         nxt = {r[0] & ((pt == 2'h1 & cmd[0]) | (pt == 2'h0 & cmd[1])), mio & cmd[2],
            mio & !cmd[2], mio & !cmd[2] & r[6], r[7] & cmd[6], r[8] & cmd[8],
            r[9] & cmd[8], r[10] & !cmd[10], r[11]};
         pri_req <= r[0];
         pri_type <= spi_req_type'(pt);
         dn_req <= r[3];
         dn_type <= spi_req_type'(dt);
         {fwd_intx, own_intx, nonfatal_err, fatal_err, parity_err, dn_nonposted} <= r[11:6];
         #1;
         check({23'h0, pri_accept, up_fwd, dn_ur, dn_ur_cpl, parity_act, err_fatal_msg,
            err_nonfatal_msg, intx_msg, intx_fwd_msg}, {23'h0, exp});
         exp = nxt;
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      rdchk(SPI_OFF_IDENT, {part, maker});
      rdchk(SPI_OFF_CMD, 32'h0);
      u_rc.wr(SPI_OFF_IDENT, rnd(), 4'hF);
      rdchk(SPI_OFF_IDENT, {part, maker});
      r = rnd();
      @(posedge mclk);
      id_load <= 1'b1;
      {id_load_part, id_load_maker} <= r;
      {part, maker} = r;
      @(posedge mclk);
      id_load <= 1'b0;
      {id_load_part, id_load_maker} <= ~r;
      rdchk(SPI_OFF_IDENT, {part, maker});
      rdchk(12'h008, 32'h0);
      for (i = 0; i < 10; i++) begin
         r = (i == 0) ? 32'hFFFF : rnd();
         rd_v[3:0] = (i < 2) ? 4'h3 : r[19:16];
         m = 16'h0547 & {{8{rd_v[1]}}, {8{rd_v[0]}}};
         u_rc.wr(SPI_OFF_CMD, r, rd_v[3:0]);
         cmd = (cmd & ~m) | (r[15:0] & m);
         rdchk(SPI_OFF_CMD, {16'h0, cmd});
         events(12);
      end
      u_rc.wr(12'h008, 32'hFFFFFFFF, 4'hF);
      rdchk(SPI_OFF_CMD, {16'h0, cmd});
      give_verdict();
   end
endmodule
`default_nettype wire
